// ---- shared/lsf_pkg.sv ----
// constants, types and decode tables for the logic and sense flag datapath
// assumes one machine cycle equals one period of i_clk_sys
package lsf_pkg;

	// ************************************************************
	// widths and reset values
	// ************************************************************
	localparam int WORD_W = 36;
	localparam int HALF_W = 18;
	localparam int ADDR_W = 15;
	localparam int CNT_W  = 3;

	typedef logic [0:WORD_W-1] lsf_word_t;
	typedef logic [0:HALF_W-1] lsf_half_t;
	typedef logic [ADDR_W-1:0] lsf_addr_t;

	localparam lsf_word_t FLAGS_RESET = 36'h0_0000_0000;
	localparam lsf_word_t WORD_ZERO   = 36'h0_0000_0000;
	localparam lsf_half_t HALF_ZERO   = 18'h0_0000;

	// ************************************************************
	// address codes of the shared magnitude/sign opcode
	// ************************************************************
	localparam lsf_addr_t MS_CLEAR  = 15'h0000;
	localparam lsf_addr_t MS_FLIP   = 15'h0002;
	localparam lsf_addr_t MS_SIGN   = 15'h0003;
	localparam lsf_addr_t MS_INVERT = 15'h0006;

	// ************************************************************
	// execution times in machine cycles
	// ************************************************************
	localparam logic [CNT_W-1:0] CYC_AND_WORD  = 3'h4;
	localparam logic [CNT_W-1:0] CYC_XOR_ACC   = 3'h3;
	localparam logic [CNT_W-1:0] CYC_MAG_SIGN  = 3'h2;
	localparam logic [CNT_W-1:0] CYC_REG       = 3'h1;
	localparam logic [CNT_W-1:0] CYC_MEM       = 3'h2;
	localparam logic [CNT_W-1:0] CYC_TEST_ACC  = 3'h2;
	localparam logic [CNT_W-1:0] CYC_TEST_WORD = 3'h4;
	localparam logic [CNT_W-1:0] CYC_TEST_HALF = 3'h3;

	// ************************************************************
	// working register, operations and command
	// ************************************************************
	typedef struct packed {
		logic        sign;
		logic        ovf;
		logic        xhi;
		logic [1:35] mag;
	} lsf_acc_s;

	typedef enum logic [4:0] {
		OP_AND_WORD, OP_XOR_ACC, OP_MAG_SIGN,
		OP_ACC_TO_FLAGS, OP_FLAGS_TO_ACC, OP_LOAD_FLAGS, OP_WRITE_FLAGS,
		OP_OR_ACC, OP_OR_WORD, OP_SET_UP, OP_SET_LO,
		OP_CLR_ACC, OP_CLR_WORD, OP_CLR_UP, OP_CLR_LO,
		OP_INV_ACC, OP_INV_WORD, OP_INV_UP, OP_INV_LO,
		OP_TON_ACC, OP_TOFF_ACC, OP_SON_WORD, OP_SOFF_WORD,
		OP_SON_UP, OP_SON_LO, OP_SOFF_UP, OP_SOFF_LO
	} lsf_op_e;

	typedef enum logic [2:0] {SRC_NONE, SRC_ACC, SRC_WORD, SRC_UP, SRC_LO} lsf_src_e;
	typedef enum logic [2:0] {ACT_NONE, ACT_SET, ACT_CLR, ACT_INV, ACT_ON, ACT_OFF} lsf_act_e;

	typedef struct packed {
		lsf_op_e   op;
		logic      neg;
		lsf_addr_t addr;
		lsf_addr_t index;
		logic      index_en;
		lsf_half_t imm;
	} lsf_cmd_s;

	function automatic logic [CNT_W-1:0] lsf_cycles(input lsf_op_e op);
		case (op)
			OP_AND_WORD:                      lsf_cycles = CYC_AND_WORD;
			OP_XOR_ACC:                       lsf_cycles = CYC_XOR_ACC;
			OP_MAG_SIGN:                      lsf_cycles = CYC_MAG_SIGN;
			OP_LOAD_FLAGS, OP_WRITE_FLAGS,
			OP_OR_WORD, OP_CLR_WORD,
			OP_INV_WORD:                      lsf_cycles = CYC_MEM;
			OP_TON_ACC, OP_TOFF_ACC:          lsf_cycles = CYC_TEST_ACC;
			OP_SON_WORD, OP_SOFF_WORD:        lsf_cycles = CYC_TEST_WORD;
			OP_SON_UP, OP_SON_LO,
			OP_SOFF_UP, OP_SOFF_LO:           lsf_cycles = CYC_TEST_HALF;
			default:                          lsf_cycles = CYC_REG;
		endcase
	endfunction

	function automatic lsf_src_e lsf_src(input lsf_op_e op);
		case (op)
			OP_OR_ACC, OP_CLR_ACC, OP_INV_ACC,
			OP_TON_ACC, OP_TOFF_ACC:          lsf_src = SRC_ACC;
			OP_OR_WORD, OP_CLR_WORD, OP_INV_WORD,
			OP_SON_WORD, OP_SOFF_WORD:        lsf_src = SRC_WORD;
			OP_SET_UP, OP_CLR_UP, OP_INV_UP,
			OP_SON_UP, OP_SOFF_UP:            lsf_src = SRC_UP;
			OP_SET_LO, OP_CLR_LO, OP_INV_LO,
			OP_SON_LO, OP_SOFF_LO:            lsf_src = SRC_LO;
			default:                          lsf_src = SRC_NONE;
		endcase
	endfunction

	function automatic lsf_act_e lsf_act(input lsf_op_e op);
		case (op)
			OP_OR_ACC, OP_OR_WORD, OP_SET_UP, OP_SET_LO:   lsf_act = ACT_SET;
			OP_CLR_ACC, OP_CLR_WORD, OP_CLR_UP, OP_CLR_LO: lsf_act = ACT_CLR;
			OP_INV_ACC, OP_INV_WORD, OP_INV_UP, OP_INV_LO: lsf_act = ACT_INV;
			OP_TON_ACC, OP_SON_WORD, OP_SON_UP, OP_SON_LO: lsf_act = ACT_ON;
			OP_TOFF_ACC, OP_SOFF_WORD,
			OP_SOFF_UP, OP_SOFF_LO:                        lsf_act = ACT_OFF;
			default:                                       lsf_act = ACT_NONE;
		endcase
	endfunction

endpackage

// ---- verif/lsf_logic_unit_props.sv ----
// concurrent checks on the ports of the logic and sense flag datapath
// assumes the bench holds i_ce high except in t_hold; counts below assume it never stretches
`timescale 1ns/1ps
`default_nettype none

module lsf_logic_unit_props #(
	parameter int CNT_W = 3
) (
	// clock, reset, enable
	input  wire logic               i_clk_sys,
	input  wire logic               i_rst,
	input  wire logic               i_ce,
	// command side
	input  wire logic               i_start,
	input  wire lsf_pkg::lsf_cmd_s  i_cmd,
	input  wire lsf_pkg::lsf_acc_s  i_acc,
	input  wire lsf_pkg::lsf_word_t i_word,
	// result side
	input  wire logic               o_busy,
	input  wire logic               o_done,
	input  wire logic               o_acc_we,
	input  wire lsf_pkg::lsf_acc_s  o_acc,
	input  wire logic               o_store_we,
	input  wire lsf_pkg::lsf_word_t o_store_word,
	input  wire logic               o_transfer,
	input  wire logic               o_skip,
	input  wire lsf_pkg::lsf_word_t o_sense_flags
);
	import lsf_pkg::*;

	// ************************************************************
	// helpers and assertions
	// ************************************************************
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	wire logic      take = i_start && i_ce && !o_busy;
	// decode must see the address after index modification
	wire lsf_addr_t eff  = i_cmd.addr - (i_cmd.index_en ? i_cmd.index : 15'h0000);
	wire lsf_word_t am   = {i_acc.xhi, i_acc.mag};

	and_store_a: assert property (take && i_cmd.op == OP_AND_WORD |->
		##1 o_busy[*4] ##1 (o_store_we && !o_acc_we
		&& o_store_word == ($past(am, 5) & $past(i_word, 5))))
		else $error("and_into_word result or timing wrong");
	xor_acc_a: assert property (take && i_cmd.op == OP_XOR_ACC |->
		##1 o_busy[*3] ##1 (o_acc_we && !o_store_we
		&& o_acc == {2'b00, $past(am, 4) ^ $past(i_word, 4)}))
		else $error("xor_into_acc result or timing wrong");
	mag_time_a: assert property (take && i_cmd.op == OP_MAG_SIGN |->
		##1 o_busy[*2] ##1 o_done)
		else $error("magnitude or sign op took wrong time");
	flip_sign_a: assert property (take && i_cmd.op == OP_MAG_SIGN && eff == MS_FLIP |->
		##3 (o_acc_we && (o_acc ^ $past(i_acc, 3)) == 38'h20_0000_0000))
		else $error("flip_sign changed wrong bits");
	inv_mag_a: assert property (take && i_cmd.op == OP_MAG_SIGN && eff == MS_INVERT |->
		##3 (o_acc_we && (o_acc ^ $past(i_acc, 3)) == 38'h1F_FFFF_FFFF))
		else $error("invert_magnitude changed wrong bits");
	force_sign_a: assert property (take && i_cmd.op == OP_MAG_SIGN && eff == MS_SIGN |->
		##3 (o_acc.sign == $past(i_cmd.neg, 3) && o_acc[36:0] == $past(i_acc[36:0], 3)))
		else $error("forced sign wrong");
	to_flags_a: assert property (take && i_cmd.op == OP_ACC_TO_FLAGS |->
		##1 o_busy ##1 (o_done && !o_acc_we && o_sense_flags == $past(am, 2)))
		else $error("acc_to_flags result or timing wrong");
	clr_acc_a: assert property (take && i_cmd.op == OP_CLR_ACC |->
		##2 o_sense_flags == ($past(o_sense_flags, 2) & ~$past(am, 2)))
		else $error("clear_flags_by_acc result wrong");
	set_upper_a: assert property (take && i_cmd.op == OP_SET_UP |->
		##2 o_sense_flags == ($past(o_sense_flags, 2) | {$past(i_cmd.imm, 2), 18'h0_0000}))
		else $error("set_upper_flags_imm result wrong");
	flag_hold_a: assert property ($changed(o_sense_flags) |-> o_done)
		else $error("flags changed outside completion");
	strobe_done_a: assert property (o_acc_we || o_store_we || o_transfer || o_skip |-> o_done)
		else $error("strobe without completion");
endmodule

bind lsf_logic_unit lsf_logic_unit_props #(.CNT_W(CNT_W)) u_lsf_logic_unit_props (
	.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce), .i_start(i_start), .i_cmd(i_cmd),
	.i_acc(i_acc), .i_word(i_word), .o_busy(o_busy), .o_done(o_done), .o_acc_we(o_acc_we),
	.o_acc(o_acc), .o_store_we(o_store_we), .o_store_word(o_store_word),
	.o_transfer(o_transfer), .o_skip(o_skip), .o_sense_flags(o_sense_flags)
);
`default_nettype wire

// ---- verif/lsf_seq_mem.sv ----
// model of the sequencer's working register and one storage word
// assumes the bench preloads it between operations, never during one
`timescale 1ns/1ps
`default_nettype none

module lsf_seq_mem (
	// clock and reset
	input  wire logic               i_clk_sys,
	input  wire logic               i_rst,
	// preload from the bench
	input  wire logic               i_load,
	input  wire lsf_pkg::lsf_acc_s  i_acc_init,
	input  wire lsf_pkg::lsf_word_t i_word_init,
	// write-back from the block
	input  wire logic               i_acc_we,
	input  wire lsf_pkg::lsf_acc_s  i_acc_new,
	input  wire logic               i_store_we,
	input  wire lsf_pkg::lsf_word_t i_store_new,
	// operands toward the block
	output var  lsf_pkg::lsf_acc_s  o_acc,
	output var  lsf_pkg::lsf_word_t o_word
);
	import lsf_pkg::*;

	// ************************************************************
	// storage
	// ************************************************************
	// operands stand still from before start until write-back
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_acc  <= '0;
			o_word <= WORD_ZERO;
		end else if (i_load) begin
			o_acc  <= i_acc_init;
			o_word <= i_word_init;
		end else begin
			if (i_acc_we)
				o_acc <= i_acc_new;
			if (i_store_we)
				o_word <= i_store_new;
		end
	end
endmodule
`default_nettype wire

// ---- verif/tb_lsf_logic_unit.sv ----
// self-checking bench for the logic and sense flag datapath
// assumes the checker is bound in and the partner model holds the operands
`timescale 1ns/1ps
`default_nettype none

module tb_lsf_logic_unit;
	import lsf_pkg::*;

	logic      clk_sys, rst, ce, start, ld, busy, done, acc_we, store_we, xfer, skip, xs, ss;
	lsf_cmd_s  cmd;
	lsf_acc_s  acc, acc_out, acc_init;
	lsf_word_t word, store_word, flags, word_init, f;
	int        n_mismatch, total_checks, cyc;
	// sign and ovf set so clearing and forcing are visible
	localparam lsf_acc_s MA = '{1'b1, 1'b1, 1'b0, 35'h2_0F0F_0F0F};
	localparam lsf_word_t W1 = 36'h8_0000_0001;

	lsf_logic_unit #(.CNT_W(3)) u_lsf_logic_unit (
		.i_clk_sys(clk_sys), .i_rst(rst), .i_ce(ce), .i_start(start), .i_cmd(cmd),
		.i_acc(acc), .i_word(word), .o_busy(busy), .o_done(done), .o_acc_we(acc_we),
		.o_acc(acc_out), .o_store_we(store_we), .o_store_word(store_word),
		.o_transfer(xfer), .o_skip(skip), .o_sense_flags(flags));
	lsf_seq_mem u_lsf_seq_mem (
		.i_clk_sys(clk_sys), .i_rst(rst), .i_load(ld), .i_acc_init(acc_init),
		.i_word_init(word_init), .i_acc_we(acc_we), .i_acc_new(acc_out),
		.i_store_we(store_we), .i_store_new(store_word), .o_acc(acc), .o_word(word));

	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic preload(input lsf_acc_s a, input lsf_word_t w);
		@(posedge clk_sys);
		ld <= 1'b1;
		acc_init <= a;
		word_init <= w;
		@(posedge clk_sys);
		ld <= 1'b0;
	endtask

	// counts edges from take to done, then lets the partner write back
	task automatic run(input lsf_op_e op, input lsf_addr_t ad, input lsf_addr_t ix,
			input logic ng, input lsf_half_t imm, input int n);
		int k;
		@(posedge clk_sys);
		cmd <= '{op, ng, ad, ix, ix != 15'h0000, imm};
		start <= 1'b1;
		@(posedge clk_sys);
		start <= 1'b0;
		k = 0;
		do begin
			@(posedge clk_sys);
			#1;
			k++;
		end while (done !== 1'b1 && k < 20);
		xs = xfer;
		ss = skip;
		check("cycles", k, n);
		@(posedge clk_sys);
		#1;
	endtask

	task automatic mag(input lsf_acc_s a, input lsf_addr_t ad, input lsf_addr_t ix,
			input logic ng, input lsf_acc_s e);
		preload(a, WORD_ZERO);
		run(OP_MAG_SIGN, ad, ix, ng, HALF_ZERO, 2);
		check("mag sign acc", acc, e);
	endtask

	task automatic flg(input lsf_op_e op, input lsf_half_t imm, input int n);
		run(op, 15'h0000, 15'h0000, 1'b0, imm, n);
		check("flags", flags, f);
	endtask

	task automatic tst(input lsf_op_e op, input lsf_half_t imm, input int n, input logic e);
		run(op, 15'h0000, 15'h0000, 1'b0, imm, n);
		check("skip", ss, e);
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_and_xor();
		lsf_word_t w2;
		preload(MA, 36'h9_3C3C_3C3C);
		w2 = {MA.xhi, MA.mag} & 36'h9_3C3C_3C3C;
		run(OP_AND_WORD, 15'h0000, 15'h0000, 1'b0, HALF_ZERO, 4);
		check("and word", word, w2);
		check("and acc", acc, MA);
		run(OP_XOR_ACC, 15'h0000, 15'h0000, 1'b0, HALF_ZERO, 3);
		check("xor acc", acc, {2'b00, {MA.xhi, MA.mag} ^ w2});
		check("xor word", word, w2);
	endtask

	task automatic t_mag_sign();
		mag(MA, MS_CLEAR, 15'h0000, 1'b0, {MA.sign, 37'h0});
		mag(MA, 15'h0008, 15'h0002, 1'b0, MA ^ 38'h1F_FFFF_FFFF);
		mag(MA, MS_FLIP, 15'h0000, 1'b0, MA ^ 38'h20_0000_0000);
		mag(MA, MS_SIGN, 15'h0000, 1'b0, {1'b0, MA[36:0]});
		mag({1'b0, MA[36:0]}, MS_SIGN, 15'h0000, 1'b1, MA);
	endtask

	task automatic t_words();
		preload(MA, 36'hF_0000_FFFF);
		f = 36'hF_0000_FFFF;
		flg(OP_LOAD_FLAGS, HALF_ZERO, 2);
		run(OP_FLAGS_TO_ACC, 15'h0000, 15'h0000, 1'b0, HALF_ZERO, 1);
		check("flags to acc", acc, {2'b00, f});
		preload(MA, WORD_ZERO);
		f = {MA.xhi, MA.mag};
		flg(OP_ACC_TO_FLAGS, HALF_ZERO, 1);
		run(OP_WRITE_FLAGS, 15'h0000, 15'h0000, 1'b0, HALF_ZERO, 2);
		check("store flags", word, f);
	endtask

	task automatic t_set_clr();
		preload(MA, W1);
		f |= W1;
		flg(OP_OR_WORD, HALF_ZERO, 2);
		f |= {18'h3_0001, 18'h0_0000};
		flg(OP_SET_UP, 18'h3_0001, 1);
		f |= {18'h0_0000, 18'h0_00F0};
		flg(OP_SET_LO, 18'h0_00F0, 1);
		f &= ~{MA.xhi, MA.mag};
		flg(OP_CLR_ACC, HALF_ZERO, 1);
		f &= ~W1;
		flg(OP_CLR_WORD, HALF_ZERO, 2);
		f &= ~{18'h0_00F0, HALF_ZERO};
		flg(OP_CLR_UP, 18'h0_00F0, 1);
		f &= ~{HALF_ZERO, 18'h3_0001};
		flg(OP_CLR_LO, 18'h3_0001, 1);
		f ^= {18'h2_4000, HALF_ZERO};
		flg(OP_INV_UP, 18'h2_4000, 1);
		f ^= {HALF_ZERO, 18'h0_0F00};
		flg(OP_INV_LO, 18'h0_0F00, 1);
		f ^= W1;
		flg(OP_INV_WORD, HALF_ZERO, 2);
		f ^= {MA.xhi, MA.mag};
		flg(OP_INV_ACC, HALF_ZERO, 1);
		f |= {MA.xhi, MA.mag};
		flg(OP_OR_ACC, HALF_ZERO, 1);
	endtask

	task automatic t_tests();
		preload(MA, ~f);
		run(OP_TON_ACC, 15'h0000, 15'h0000, 1'b0, HALF_ZERO, 2);
		check("on test", xs, 1'b1);
		run(OP_TOFF_ACC, 15'h0000, 15'h0000, 1'b0, HALF_ZERO, 2);
		check("off test", xs, 1'b0);
		tst(OP_SOFF_WORD, HALF_ZERO, 4, 1'b1);
		tst(OP_SON_UP, f[0:17], 3, 1'b1);
		tst(OP_SON_WORD, HALF_ZERO, 4, 1'b0);
		tst(OP_SON_LO, f[18:35], 3, 1'b1);
		tst(OP_SOFF_UP, ~f[0:17], 3, 1'b1);
		tst(OP_SOFF_LO, f[18:35], 3, 1'b0);
		check("flags kept", flags, f);
	endtask

	// enable low for two cycles stretches the op; the invert lands once
	task automatic t_hold();
		f ^= {MA.xhi, MA.mag};
		fork
			flg(OP_INV_ACC, HALF_ZERO, 3);
			begin
				repeat (2) @(posedge clk_sys);
				ce <= 1'b0;
				repeat (2) @(posedge clk_sys);
				ce <= 1'b1;
			end
		join
	endtask

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			summarize();
		end
	end

	initial begin
		rst = 1'b1;
		ce = 1'b1;
		start = 1'b0;
		ld = 1'b0;
		cmd = '0;
		acc_init = '0;
		word_init = WORD_ZERO;
		repeat (12) @(posedge clk_sys);
		rst <= 1'b0;
		check("flags reset", flags, FLAGS_RESET);
		t_and_xor();
		t_mag_sign();
		t_words();
		t_set_clr();
		t_tests();
		t_hold();
		summarize();
	end
endmodule
`default_nettype wire

// ---- verilog/lsf_logic_unit.sv ----
// logic and sense flag datapath: logical storage/accumulator operations,
// the magnitude and sign group, and every sense flag operation
// assumes the sequencer supplies a decoded command, the working register
// and the storage operand with i_start, and writes back on the strobes
//
// Function
// RULE1 - and_into_word stores working reg AND operand, xhi paired with sign; 4 cycles
// RULE2 - xor_into_acc puts operand XOR working reg in acc, clears sign and ovf; 3 cycles
// RULE3 - invert_magnitude complements ovf, xhi and 1-35, sign kept; 2 cycles
// RULE4 - zero_magnitude clears ovf, xhi and 1-35, sign kept; 2 cycles
// RULE5 - index modification applies before the shared opcode's address decode
// RULE6 - flip_sign inverts only the working register sign; 2 cycles
// RULE7 - force_sign_positive sets sign to 0, rest untouched; 2 cycles
// RULE8 - force_sign_negative sets sign to 1, rest untouched; 2 cycles
// RULE9 - 36-bit sense flags; only mask ones are modified or tested
// RULE10 - masked invert complements selected flags, others unchanged
// RULE11 - on-test: all selected flags one gives transfer or skip
// RULE12 - off-test: all selected flags zero gives transfer or skip
// RULE13 - acc_to_flags copies xhi and 1-35 into flags 0-35; 1 cycle
// RULE14 - flags_to_acc copies flags to xhi,1-35, clears sign and ovf; 1 cycle
// RULE15 - load_flags_from_word loads operand sign and 1-35 into flags; 2 cycles
// RULE16 - write_flags_to_word stores flags into operand sign and 1-35; 2 cycles
// RULE17 - or_acc_into_flags ORs xhi and 1-35 into flags; 1 cycle
// RULE18 - or_word_into_flags ORs operand into flags; 2 cycles
// RULE19 - set_upper_flags_imm ORs immediate half into flags 0-17; 1 cycle
// RULE20 - set_lower_flags_imm ORs immediate half into flags 18-35; 1 cycle
// RULE21 - clear_flags_by_acc: each acc one clears the matching flag; 1 cycle
// RULE22 - clear_flags_by_word same with operand as mask; 2 cycles
// RULE23 - words are plain bits; xhi stands in for the sign position
// RULE24 - done pulses exactly after the cycle count; operands given at start
// RULE25 - nothing outside flags, working register and operand is changed
`timescale 1ns/1ps
`default_nettype none

module lsf_logic_unit #(
	parameter int CNT_W = 3
) (
	// clock, reset, enable
	input  wire logic             i_clk_sys,
	input  wire logic             i_rst,
	input  wire logic             i_ce,
	// command from the sequencer
	input  wire logic             i_start,
	input  wire lsf_pkg::lsf_cmd_s  i_cmd,
	input  wire lsf_pkg::lsf_acc_s  i_acc,
	input  wire lsf_pkg::lsf_word_t i_word,
	// completion and results
	output logic                  o_busy,
	output logic                  o_done,
	output logic                  o_acc_we,
	output lsf_pkg::lsf_acc_s     o_acc,
	output logic                  o_store_we,
	output lsf_pkg::lsf_word_t    o_store_word,
	output logic                  o_transfer,
	output logic                  o_skip,
	// sense flag state
	output lsf_pkg::lsf_word_t    o_sense_flags
);
	import lsf_pkg::*;

	// ************************************************************
	// elaboration checks
	// ************************************************************
	if (CNT_W < lsf_pkg::CNT_W) begin : g_cnt_check
		$error("CNT_W too small for the longest operation");
	end

	// ************************************************************
	// helper functions
	// ************************************************************
	// the working register seen as a 36-bit word, xhi in the sign place
	function automatic lsf_word_t acc_bits(input lsf_acc_s a);
		acc_bits = {a.xhi, a.mag}; // RULE23
	endfunction

	function automatic lsf_word_t place_half(input lsf_half_t h, input logic upper);
		place_half = upper ? {h, HALF_ZERO} : {HALF_ZERO, h};
	endfunction

	// ************************************************************
	// captured command and operands
	// ************************************************************
	lsf_cmd_s          cmd_q;
	lsf_acc_s          acc_q;
	lsf_word_t         word_q;
	lsf_addr_t         eff_addr_q;
	logic [CNT_W-1:0]  cnt;

	wire logic         take;
	wire logic         finish;
	wire lsf_addr_t    eff_addr;
	wire logic [CNT_W-1:0] start_cnt;

	assign take   = i_ce && i_start && !o_busy;
	assign finish = i_ce && o_busy && (cnt == '0);

	// address modification is a subtraction of the index value; it must
	// happen before decode since it may pick a different operation
	assign eff_addr = i_cmd.index_en ? (i_cmd.addr - i_cmd.index) : i_cmd.addr; // RULE5

	// count is loaded with cycles minus one so done lands after exactly N edges
	assign start_cnt = CNT_W'(lsf_cycles(i_cmd.op) - 3'h1); // RULE24

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			cmd_q      <= '0;
			acc_q      <= '0;
			word_q     <= WORD_ZERO;
			eff_addr_q <= '0;
		end else if (take) begin
			cmd_q      <= i_cmd;
			acc_q      <= i_acc;
			word_q     <= i_word;
			eff_addr_q <= eff_addr;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_busy <= 1'b0;
			cnt    <= '0;
		end else if (i_ce) begin
			if (take) begin
				o_busy <= 1'b1;
				cnt    <= start_cnt;
			end else if (finish) begin
				o_busy <= 1'b0;
			end else if (o_busy) begin
				cnt    <= cnt - 1'b1;
			end
		end
	end

	// ************************************************************
	// operation decode
	// ************************************************************
	wire lsf_src_e  src;
	wire lsf_act_e  act;
	wire lsf_word_t acc_w;
	wire lsf_word_t mask;
	wire logic      is_ms;
	wire logic      ms_clear;
	wire logic      ms_invert;
	wire logic      ms_flip;
	wire logic      ms_sign;

	assign src   = lsf_src(cmd_q.op);
	assign act   = lsf_act(cmd_q.op);
	assign acc_w = acc_bits(acc_q);

	// one mask selection serves set, reset, invert and test alike
	assign mask = (src == SRC_ACC)  ? acc_w :
	              (src == SRC_WORD) ? word_q :
	              (src == SRC_UP)   ? place_half(cmd_q.imm, 1'b1) :
	              (src == SRC_LO)   ? place_half(cmd_q.imm, 1'b0) :
	                                  WORD_ZERO; // RULE9

	assign is_ms     = (cmd_q.op == OP_MAG_SIGN);
	assign ms_clear  = is_ms && (eff_addr_q == MS_CLEAR);
	assign ms_invert = is_ms && (eff_addr_q == MS_INVERT);
	assign ms_flip   = is_ms && (eff_addr_q == MS_FLIP);
	assign ms_sign   = is_ms && (eff_addr_q == MS_SIGN);

	// ************************************************************
	// working register result
	// ************************************************************
	wire lsf_word_t xor_w;
	wire logic      acc_wr;
	lsf_acc_s       next_acc;

	assign xor_w = word_q ^ acc_w; // RULE23

	// unknown address codes of the shared opcode complete with no write
	assign acc_wr = (cmd_q.op == OP_XOR_ACC) || (cmd_q.op == OP_FLAGS_TO_ACC) ||
	                ms_clear || ms_invert || ms_flip || ms_sign;

	always_comb begin
		next_acc = acc_q;
		case (1'b1)
			(cmd_q.op == OP_XOR_ACC): begin
				next_acc.sign = 1'b0; // RULE2
				next_acc.ovf  = 1'b0; // RULE2
				next_acc.xhi  = xor_w[0]; // RULE2
				next_acc.mag  = xor_w[1:35]; // RULE2
			end
			(cmd_q.op == OP_FLAGS_TO_ACC): begin
				next_acc.sign = 1'b0; // RULE14
				next_acc.ovf  = 1'b0; // RULE14
				next_acc.xhi  = o_sense_flags[0]; // RULE14
				next_acc.mag  = o_sense_flags[1:35]; // RULE14
			end
			ms_clear: begin
				next_acc.ovf = 1'b0; // RULE4
				next_acc.xhi = 1'b0; // RULE4
				next_acc.mag = '0; // RULE4
			end
			ms_invert: begin
				next_acc.ovf = ~acc_q.ovf; // RULE3
				next_acc.xhi = ~acc_q.xhi; // RULE3
				next_acc.mag = ~acc_q.mag; // RULE3
			end
			ms_flip: begin
				next_acc.sign = ~acc_q.sign; // RULE6
			end
			ms_sign: begin
				// opcode sign picks minus or plus for the same address code
				next_acc.sign = cmd_q.neg; // RULE7 RULE8
			end
			default: begin
				next_acc = acc_q;
			end
		endcase
	end

	// ************************************************************
	// storage result
	// ************************************************************
	wire logic      store_wr;
	wire lsf_word_t next_store;

	assign store_wr   = (cmd_q.op == OP_AND_WORD) || (cmd_q.op == OP_WRITE_FLAGS);
	assign next_store = (cmd_q.op == OP_AND_WORD) ? (acc_w & word_q) // RULE1
	                                              : o_sense_flags; // RULE16

	// ************************************************************
	// sense flag update
	// ************************************************************
	wire logic      flag_load;
	wire lsf_word_t flag_load_val;
	wire lsf_word_t flag_set;
	wire lsf_word_t flag_clr;
	wire lsf_word_t flag_inv;

	assign flag_load     = (cmd_q.op == OP_ACC_TO_FLAGS) || (cmd_q.op == OP_LOAD_FLAGS);
	assign flag_load_val = (cmd_q.op == OP_LOAD_FLAGS) ? word_q // RULE15
	                                                   : acc_w; // RULE13
	// set covers the acc, word and both immediate halves
	assign flag_set = (act == ACT_SET) ? mask : WORD_ZERO; // RULE17 RULE18 RULE19 RULE20
	assign flag_clr = (act == ACT_CLR) ? mask : WORD_ZERO; // RULE21 RULE22
	assign flag_inv = (act == ACT_INV) ? mask : WORD_ZERO; // RULE10

	lsf_sense_reg u_sense (
		.i_clk_sys  (i_clk_sys),
		.i_rst      (i_rst),
		.i_ce       (i_ce),
		.i_apply    (finish),
		.i_load     (flag_load),
		.i_load_val (flag_load_val),
		.i_set      (flag_set),
		.i_clr      (flag_clr),
		.i_inv      (flag_inv),
		.o_flags    (o_sense_flags)
	);

	// ************************************************************
	// masked tests
	// ************************************************************
	wire lsf_word_t sel;
	wire logic      all_on;
	wire logic      all_off;
	wire logic      hit;
	wire logic      is_transfer;

	// an empty mask examines nothing, so both tests succeed
	assign sel     = o_sense_flags & mask;
	assign all_on  = (sel == mask); // RULE11
	assign all_off = (sel == WORD_ZERO); // RULE12
	assign hit     = ((act == ACT_ON) && all_on) || ((act == ACT_OFF) && all_off);
	// only the accumulator-masked tests transfer; the rest skip
	assign is_transfer = (src == SRC_ACC);

	// ************************************************************
	// result strobes
	// ************************************************************
	// strobes stand until the next edge with i_ce high; data outputs hold until the next finish
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_done       <= 1'b0;
			o_acc_we     <= 1'b0;
			o_store_we   <= 1'b0;
			o_transfer   <= 1'b0;
			o_skip       <= 1'b0;
			o_acc        <= '0;
			o_store_word <= WORD_ZERO;
		end else if (i_ce) begin
			o_done     <= finish; // RULE24
			o_acc_we   <= finish && acc_wr; // RULE25
			o_store_we <= finish && store_wr; // RULE1 RULE16
			o_transfer <= finish && hit && is_transfer; // RULE11 RULE12
			o_skip     <= finish && hit && !is_transfer; // RULE11 RULE12
			if (finish) begin
				o_acc        <= next_acc;
				o_store_word <= next_store;
			end
		end
	end

endmodule

`default_nettype wire

// ---- verilog/lsf_sense_reg.sv ----
// the 36-position sense flag register with load, set, reset and invert inputs
// assumes the caller asserts i_apply for exactly one cycle per operation
`timescale 1ns/1ps
`default_nettype none

module lsf_sense_reg (
	// clock and reset
	input  wire logic             i_clk_sys,
	input  wire logic             i_rst,
	input  wire logic             i_ce,
	// update request
	input  wire logic             i_apply,
	input  wire logic             i_load,
	input  wire lsf_pkg::lsf_word_t i_load_val,
	input  wire lsf_pkg::lsf_word_t i_set,
	input  wire lsf_pkg::lsf_word_t i_clr,
	input  wire lsf_pkg::lsf_word_t i_inv,
	// state
	output var  lsf_pkg::lsf_word_t o_flags
);
	import lsf_pkg::*;

	lsf_word_t next_flags;

	// outside a load, positions with a zero in every mask keep their value
	assign next_flags = i_load ? i_load_val : (((o_flags | i_set) & ~i_clr) ^ i_inv); // RULE9

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_flags <= FLAGS_RESET;
		end else if (i_ce && i_apply) begin
			o_flags <= next_flags;
		end
	end

endmodule

`default_nettype wire
